// ---- core/tpcw_pkg.sv ----
// Constants and types for the transmit packet control word block
package tpcw_pkg;
    localparam int CLK_NS = 4;
    localparam int BYTE_NS = 80;
    localparam int BYTE_CYC = (BYTE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOT_NS = 5120;
    localparam int FAST_SLOT_NS = 1280;
    localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAST_SLOT_CYC = (FAST_SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] ADDR_PCW = 10'h000;
    localparam logic [9:0] ADDR_LEN = 10'h004;
    localparam logic [9:0] ADDR_SETUP = 10'h008;
    localparam logic [9:0] ADDR_DATA = 10'h00C;
    localparam logic [9:0] ADDR_STATUS = 10'h108;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [31:0] PCW_RESET = 32'h0000_0000;
    localparam logic [31:0] PCW_MASK = 32'h3FFF_FF7E;
    localparam int PRELOAD_LSB = 25;
    localparam int PRELOAD_W = 5;
    localparam int ID_LSB = 16;
    localparam int ID_W = 9;
    localparam int IPOFF_LSB = 10;
    localparam int IPOFF_W = 6;
    localparam int APPEND_BIT = 9;
    localparam int FIX_BIT = 8;
    localparam int NOPAD_BIT = 6;
    localparam int LATE_BIT = 5;
    localparam int EARLY_BIT = 4;
    localparam int COLLI_BIT = 3;
    localparam int FAST_BIT = 1;
    localparam int STAT_ABORT_BIT = 9;
    localparam int STAT_BUSY_BIT = 10;
    localparam int STAT_VALID_BIT = 31;
    localparam int MEM_WORDS = 512;
    localparam logic [16:0] MIN_FRAME = 17'h00040;
    localparam logic [16:0] CRC_BYTES = 17'h00004;
    localparam logic [15:0] IP_HDR_BYTES = 16'h0014;
    localparam logic [15:0] CSUM_HI = 16'h000A;
    localparam logic [15:0] CSUM_LO = 16'h000B;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic [4:0] BO_LIMIT = 5'h0A;
    localparam logic [9:0] LFSR_SEED = 10'h001;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_PRELOAD = 4'h2,
        S_SEND = 4'h4,
        S_BACKOFF = 4'h8
    } tpcw_state_t;
endpackage : tpcw_pkg

// ---- core/tpcw_crc32.sv ----
// Byte-wide update of the Ethernet frame check sequence
`timescale 1ns/10ps
`default_nettype none
module tpcw_crc32 (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        c = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data_in[i]) begin
                c = (c >> 1) ^ tpcw_pkg::CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        crc_out = c;
    end
endmodule : tpcw_crc32
`default_nettype wire

// ---- core/tpcw_tx_ctrl.sv ----
// Transmit control engine: AHB-Lite registers, frame buffer and sender
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// RQ1: Hold transmission until preload bytes are buffered
// RQ2: Report packet identifier in transmit status
// RQ3: Nonzero header offset enables IP checksum correction
// RQ4: Append bit adds computed frame check sequence
// RQ5: Fix bit replaces trailing frame check sequence
// RQ6: Pad short frames unless padding disabled
// RQ7: Late notify raises interrupt at completion
// RQ8: Early notify raises interrupt at start
// RQ9: Collision interrupt when frame is abandoned
// RQ10: Fast bit shortens the back-off slot
// RQ11: Host sets word and length before setup
// RQ12: Host writes packet byte length, 16 bits
// RQ13: Reserved bits ignored; control word reads zero
module tpcw_tx_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic phy_col,
    output logic tx_en,
    output logic [7:0] tx_byte,
    output logic tx_strobe,
    output logic early_irq,
    output logic late_irq,
    output logic coll_irq,
    output logic status_valid,
    output logic [8:0] status_id,
    output logic status_abort
);
    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        return a[9:2] == r[9:2];
    endfunction : hit

    // Header bytes of one written word, checksum field left out
    function automatic logic [19:0] hdr_sum(input logic [31:0] w,
            input logic [15:0] base, input logic [15:0] off,
            input logic [15:0] dlen);
        logic [19:0] s;
        logic [15:0] p;
        logic [15:0] rel;
        s = '0;
        for (int b = 0; b < 4; b++) begin
            p = base + 16'(b);
            rel = p - off;
            if (p >= off && rel < tpcw_pkg::IP_HDR_BYTES &&
                    rel != tpcw_pkg::CSUM_HI && rel != tpcw_pkg::CSUM_LO &&
                    p < dlen) begin
                if (rel[0]) begin
                    s = s + {12'h000, w[8*b +: 8]};
                end else begin
                    s = s + {4'h0, w[8*b +: 8], 8'h00};
                end
            end
        end
        return s;
    endfunction : hdr_sum

    function automatic logic [15:0] fold(input logic [19:0] s);
        logic [16:0] t;
        t = {1'b0, s[15:0]} + {13'h0000, s[19:16]};
        t = {1'b0, t[15:0]} + {16'h0000, t[16]};
        return t[15:0];
    endfunction : fold

    function automatic logic [9:0] bo_mask(input logic [4:0] n);
        logic [10:0] m;
        m = (11'h001 << ((n > tpcw_pkg::BO_LIMIT) ? tpcw_pkg::BO_LIMIT : n));
        return 10'(m - 11'h001);
    endfunction : bo_mask

    tpcw_pkg::tpcw_state_t st;
    logic ap_valid;
    logic ap_write;
    logic [9:0] ap_addr;
    logic [31:0] pcw;
    logic [15:0] len_reg;
    logic [31:0] setup_reg;
    logic [31:0] fr_pcw;
    logic [15:0] fr_len;
    logic [31:0] mem [0:tpcw_pkg::MEM_WORDS-1];
    logic [9:0] wcount;
    logic [19:0] ip_sum;
    logic [4:0] div_cnt;
    logic byte_tick;
    logic col_meta;
    logic col_sync;
    logic [9:0] lfsr;
    logic [16:0] pos;
    logic [31:0] crc;
    logic [31:0] crc_next;
    logic [4:0] attempt;
    logic [9:0] bo_slots;
    logic [10:0] bo_cnt;
    logic stat_valid;

    wire logic wr_pcw = ap_valid && ap_write &&
        hit(ap_addr, tpcw_pkg::ADDR_PCW);
    wire logic wr_len = ap_valid && ap_write && hit(ap_addr, tpcw_pkg::ADDR_LEN);
    wire logic wr_setup = ap_valid && ap_write &&
        hit(ap_addr, tpcw_pkg::ADDR_SETUP);
    wire logic wr_data = ap_valid && ap_write &&
        hit(ap_addr, tpcw_pkg::ADDR_DATA);
    wire logic rd_acc = hsel && hready && htrans[1] && !hwrite &&
        hsize == tpcw_pkg::HSIZE_WORD;
    wire logic rd_status = rd_acc && hit(haddr[9:0], tpcw_pkg::ADDR_STATUS);
    wire logic start = wr_setup && st == tpcw_pkg::S_IDLE;

    wire logic [15:0] preload = {11'h000,
        fr_pcw[tpcw_pkg::PRELOAD_LSB +: tpcw_pkg::PRELOAD_W]};
    wire logic [15:0] ip_off = {10'h000,
        fr_pcw[tpcw_pkg::IPOFF_LSB +: tpcw_pkg::IPOFF_W]};
    wire logic fr_append = fr_pcw[tpcw_pkg::APPEND_BIT];
    wire logic fr_fix = fr_pcw[tpcw_pkg::FIX_BIT];
    wire logic fr_nopad = fr_pcw[tpcw_pkg::NOPAD_BIT];
    wire logic fr_late = fr_pcw[tpcw_pkg::LATE_BIT];
    wire logic fr_early = fr_pcw[tpcw_pkg::EARLY_BIT];
    wire logic fr_colli = fr_pcw[tpcw_pkg::COLLI_BIT];
    wire logic fr_fast = fr_pcw[tpcw_pkg::FAST_BIT];
    wire logic ip_on = ip_off != 16'h0000; // [RQ3]
    wire logic crc_on = fr_append || fr_fix;
    wire logic [15:0] loaded = {4'h0, wcount, 2'b00};
    wire logic go = loaded >= preload || loaded >= fr_len; // [RQ1]
    wire logic hdr_ready = loaded >= ip_off + tpcw_pkg::IP_HDR_BYTES ||
        loaded >= fr_len;
    wire logic [15:0] csum = ~fold(ip_sum);
    wire logic [10:0] slot_len = fr_fast ? 11'(tpcw_pkg::FAST_SLOT_CYC) :
        11'(tpcw_pkg::SLOT_CYC);

    // Fixed frames carry their own check sequence in the last four bytes
    logic [16:0] data_len;
    logic [16:0] pad_end;
    logic [16:0] frame_end;
    logic [15:0] rel;
    logic stall;
    logic [7:0] next_byte;
    always_comb begin
        data_len = {1'b0, fr_len};
        if (fr_fix) begin // [RQ5]
            data_len = (fr_len < 16'h0004) ? 17'h00000 :
                data_len - tpcw_pkg::CRC_BYTES;
        end
        pad_end = data_len;
        if (!fr_nopad) begin // [RQ6]
            if (crc_on &&
                    data_len < tpcw_pkg::MIN_FRAME - tpcw_pkg::CRC_BYTES) begin
                pad_end = tpcw_pkg::MIN_FRAME - tpcw_pkg::CRC_BYTES;
            end else if (!crc_on && data_len < tpcw_pkg::MIN_FRAME) begin
                pad_end = tpcw_pkg::MIN_FRAME;
            end
        end
        frame_end = crc_on ? pad_end + tpcw_pkg::CRC_BYTES : pad_end; // [RQ4]
        rel = pos[15:0] - ip_off;
        stall = ip_on && pos < data_len && pos[15:0] >= ip_off &&
            rel == tpcw_pkg::CSUM_HI && !hdr_ready; // [RQ3]
        next_byte = 8'h00;
        if (pos < data_len) begin
            next_byte = mem[pos[10:2]][{pos[1:0], 3'b000} +: 8];
            if (ip_on && pos[15:0] >= ip_off && rel == tpcw_pkg::CSUM_HI) begin
                next_byte = csum[15:8]; // [RQ3]
            end else if (ip_on && pos[15:0] >= ip_off &&
                    rel == tpcw_pkg::CSUM_LO) begin
                next_byte = csum[7:0]; // [RQ3]
            end
        end else if (pos >= pad_end) begin
            next_byte = ~crc[{pos[1:0] - pad_end[1:0], 3'b000} +: 8]; // [RQ4]
        end
    end

    tpcw_crc32 u_crc (
        .crc_in(crc),
        .data_in(next_byte),
        .crc_out(crc_next)
    );

    // Zero wait states; every transfer answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ap_valid <= hsel && hready && htrans[1] &&
                hsize == tpcw_pkg::HSIZE_WORD;
            ap_write <= hwrite;
            ap_addr <= haddr[9:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_acc) begin
            hrdata <= '0; // [RQ13]
            if (hit(haddr[9:0], tpcw_pkg::ADDR_LEN)) begin
                hrdata <= {16'h0000, len_reg};
            end else if (hit(haddr[9:0], tpcw_pkg::ADDR_SETUP)) begin
                hrdata <= setup_reg;
            end else if (hit(haddr[9:0], tpcw_pkg::ADDR_STATUS)) begin
                hrdata[tpcw_pkg::STAT_VALID_BIT] <= stat_valid;
                hrdata[tpcw_pkg::STAT_BUSY_BIT] <= st != tpcw_pkg::S_IDLE;
                hrdata[tpcw_pkg::STAT_ABORT_BIT] <= status_abort;
                hrdata[tpcw_pkg::ID_W-1:0] <= status_id;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcw <= tpcw_pkg::PCW_RESET;
            len_reg <= '0;
            setup_reg <= '0;
        end else begin
            if (wr_pcw) begin
                pcw <= hwdata & tpcw_pkg::PCW_MASK; // [RQ13]
            end
            if (wr_len) begin
                len_reg <= hwdata[15:0];
            end
            if (start) begin
                setup_reg <= hwdata;
            end
        end
    end

    // Word and length are captured at setup, so the host may reprogram
    // them for the next frame while this one is still on the wire
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fr_pcw <= tpcw_pkg::PCW_RESET;
            fr_len <= '0;
        end else if (start) begin
            fr_pcw <= pcw; // [RQ11]
            fr_len <= len_reg; // [RQ12]
        end
    end

    // Frames longer than the buffer are not supported; words past the last entry are dropped
    always_ff @(posedge hclk) begin
        if (wr_data && wcount < 10'(tpcw_pkg::MEM_WORDS)) begin
            mem[wcount[8:0]] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wcount <= '0;
            ip_sum <= '0;
        end else if (start) begin
            wcount <= '0;
            ip_sum <= '0;
        end else if (wr_data && wcount < 10'(tpcw_pkg::MEM_WORDS)) begin
            wcount <= wcount + 10'h001;
            if (ip_on) begin
                ip_sum <= ip_sum + hdr_sum(hwdata, loaded, ip_off, fr_len);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= '0;
            byte_tick <= 1'b0;
        end else if (div_cnt == 5'(tpcw_pkg::BYTE_CYC - 1)) begin
            div_cnt <= '0;
            byte_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 5'h01;
            byte_tick <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            col_meta <= 1'b0;
            col_sync <= 1'b0;
            lfsr <= tpcw_pkg::LFSR_SEED;
        end else begin
            col_meta <= phy_col;
            col_sync <= col_meta;
            lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= tpcw_pkg::S_IDLE;
            pos <= '0;
            crc <= tpcw_pkg::CRC_INIT;
            attempt <= '0;
            bo_slots <= '0;
            bo_cnt <= '0;
            tx_en <= 1'b0;
            tx_byte <= '0;
            tx_strobe <= 1'b0;
            early_irq <= 1'b0;
            late_irq <= 1'b0;
            coll_irq <= 1'b0;
            status_valid <= 1'b0;
            status_id <= '0;
            status_abort <= 1'b0;
        end else begin
            tx_strobe <= 1'b0;
            early_irq <= 1'b0;
            late_irq <= 1'b0;
            coll_irq <= 1'b0;
            status_valid <= 1'b0;
            case (st)
                tpcw_pkg::S_IDLE: begin
                    if (start) begin
                        st <= tpcw_pkg::S_PRELOAD;
                        attempt <= '0;
                    end
                end
                tpcw_pkg::S_PRELOAD: begin
                    if (go) begin // [RQ1]
                        st <= tpcw_pkg::S_SEND;
                        pos <= '0;
                        crc <= tpcw_pkg::CRC_INIT;
                        early_irq <= fr_early && attempt == 5'h00; // [RQ8]
                    end
                end
                tpcw_pkg::S_SEND: begin
                    if (byte_tick) begin
                        if (col_sync) begin
                            tx_en <= 1'b0;
                            attempt <= attempt + 5'h01;
                            if (attempt + 5'h01 ==
                                    tpcw_pkg::MAX_ATTEMPTS) begin
                                st <= tpcw_pkg::S_IDLE;
                                status_valid <= 1'b1;
                                status_abort <= 1'b1;
                                status_id <=
                                    fr_pcw[tpcw_pkg::ID_LSB +: tpcw_pkg::ID_W];
                                coll_irq <= fr_colli; // [RQ9]
                            end else begin
                                st <= tpcw_pkg::S_BACKOFF;
                                bo_slots <= lfsr & bo_mask(attempt + 5'h01);
                                bo_cnt <= '0;
                            end
                        end else if (pos == frame_end) begin
                            tx_en <= 1'b0;
                            st <= tpcw_pkg::S_IDLE;
                            status_valid <= 1'b1;
                            status_abort <= 1'b0;
                            status_id <= // [RQ2]
                                fr_pcw[tpcw_pkg::ID_LSB +: tpcw_pkg::ID_W];
                            late_irq <= fr_late; // [RQ7]
                        end else if (!stall) begin
                            tx_en <= 1'b1;
                            tx_byte <= next_byte;
                            tx_strobe <= 1'b1;
                            pos <= pos + 17'h00001;
                            if (pos < pad_end) begin
                                crc <= crc_next; // [RQ4] [RQ5]
                            end
                        end
                    end
                end
                tpcw_pkg::S_BACKOFF: begin
                    if (bo_slots == 10'h000) begin
                        st <= tpcw_pkg::S_PRELOAD;
                    end else if (bo_cnt == slot_len - 11'h001) begin // [RQ10]
                        bo_cnt <= '0;
                        bo_slots <= bo_slots - 10'h001;
                    end else begin
                        bo_cnt <= bo_cnt + 11'h001;
                    end
                end
                default: begin
                    st <= tpcw_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Set wins over the read that clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_valid <= 1'b0;
        end else if (status_valid) begin
            stat_valid <= 1'b1;
        end else if (rd_status) begin
            stat_valid <= 1'b0;
        end
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rd_pcw_s;
        rd_acc && hit(haddr[9:0], tpcw_pkg::ADDR_PCW);
    endsequence
    sequence launch_s;
        st == tpcw_pkg::S_PRELOAD && go && attempt == 5'h00 && fr_early;
    endsequence

    preload_wait_a: assert property ($rose(tx_en) |-> // [RQ1]
        $past(loaded) >= preload || $past(loaded) >= fr_len)
        else $error("frame started before preload bytes were buffered");
    status_id_a: assert property (status_valid |-> // [RQ2]
        status_id == fr_pcw[tpcw_pkg::ID_LSB +: tpcw_pkg::ID_W])
        else $error("status identifier differs from control word");
    csum_stall_a: assert property ((st == tpcw_pkg::S_SEND && // [RQ3]
        byte_tick && stall && !col_sync) |=> !tx_strobe && pos == $past(pos))
        else $error("checksum byte sent before header was loaded");
    crc_append_a: assert property ((tx_strobe && !crc_on) |-> // [RQ4]
        pos <= pad_end)
        else $error("bytes sent past padding without check sequence");
    fix_crc_a: assert property ((st == tpcw_pkg::S_SEND && fr_fix && // [RQ5]
        fr_len >= 16'h0004) |-> frame_end == pad_end + tpcw_pkg::CRC_BYTES &&
        data_len == {1'b0, fr_len} - tpcw_pkg::CRC_BYTES)
        else $error("fixed frame does not replace its last four bytes");
    pad_min_a: assert property ((status_valid && !status_abort && // [RQ6]
        !fr_nopad) |-> pos >= tpcw_pkg::MIN_FRAME)
        else $error("padded frame shorter than minimum");
    late_irq_a: assert property (late_irq |-> // [RQ7]
        fr_late && status_valid && !status_abort)
        else $error("late notify without completed frame");
    early_irq_a: assert property (launch_s |=> // [RQ8]
        early_irq ##1 !early_irq)
        else $error("early notify missing at frame start");
    coll_irq_a: assert property (coll_irq |-> // [RQ9]
        fr_colli && status_abort && status_valid)
        else $error("collision interrupt without abandoned frame");
    backoff_slot_a: assert property (st == tpcw_pkg::S_BACKOFF |-> // [RQ10]
        bo_cnt < (fr_fast ? 11'(tpcw_pkg::FAST_SLOT_CYC) :
        11'(tpcw_pkg::SLOT_CYC)))
        else $error("back-off slot length wrong");
    pcw_read_a: assert property (rd_pcw_s |=> hrdata == '0) // [RQ13]
        else $error("control word read returned data");
endmodule : tpcw_tx_ctrl
`default_nettype wire

// ---- verification/tpcw_phy_model.sv ----
// Line-side model: collects sent bytes and can force one collision
`timescale 1ns/10ps
`default_nettype none
module tpcw_phy_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tx_en,
    input wire logic [7:0] tx_byte,
    input wire logic tx_strobe,
    input wire logic col_req,
    output logic phy_col,
    output logic [15:0] nbytes
);
    logic [7:0] rx [0:127];
    logic en_d;
    logic col_done;
    always_ff @(posedge hclk) begin
        if (tx_strobe) begin
            rx[(tx_en && !en_d) ? 7'h00 : nbytes[6:0]] <= tx_byte;
        end
    end
    // Collision only while the frame is on the wire, as a real line would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_d <= 1'b0;
            nbytes <= 16'h0000;
            phy_col <= 1'b0;
            col_done <= 1'b0;
        end else begin
            en_d <= tx_en;
            if (tx_en && !en_d) begin
                nbytes <= {15'h0000, tx_strobe};
            end else if (tx_strobe) begin
                nbytes <= nbytes + 16'h0001;
            end
            phy_col <= tx_en && (phy_col || (col_req && !col_done
                && nbytes == 16'h0002));
            col_done <= col_req && (col_done || phy_col);
        end
    end
endmodule : tpcw_phy_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Register-level bench for the transmit control word block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic hclk, hresetn, hsel, hwrite, col_req, hreadyout, hresp, phy_col;
    logic tx_en, tx_strobe, early_irq, late_irq, coll_irq;
    logic status_valid, status_abort;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] tx_byte;
    logic [8:0] status_id;
    logic [15:0] nbytes;
    int fails, checks, n_early, n_late, n_stat, n_coll;
    tpcw_tx_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .phy_col(phy_col),
        .tx_en(tx_en), .tx_byte(tx_byte), .tx_strobe(tx_strobe),
        .early_irq(early_irq), .late_irq(late_irq), .coll_irq(coll_irq),
        .status_valid(status_valid), .status_id(status_id),
        .status_abort(status_abort));
    tpcw_phy_model u_phy (.hclk(hclk), .hresetn(hresetn), .tx_en(tx_en),
        .tx_byte(tx_byte), .tx_strobe(tx_strobe), .col_req(col_req),
        .phy_col(phy_col), .nbytes(nbytes));
    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        n_early += int'(early_irq === 1'b1);
        n_late += int'(late_irq === 1'b1);
        n_stat += int'(status_valid === 1'b1);
        n_coll += int'(coll_irq === 1'b1);
    end
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // One single transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a,
            input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
        logic [31:0] c;
        c = tpcw_pkg::CRC_INIT;
        foreach (q[i]) begin
            c ^= {24'h000000, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? (c >> 1) ^ tpcw_pkg::CRC_POLY : c >> 1;
            end
        end
        return ~c;
    endfunction : crc_of
    // Loads one frame, expects it on the line byte for byte
    task automatic run(input logic [31:0] pcw, input int len,
            input int hold, input logic col);
        logic [7:0] q[$];
        logic [31:0] c;
        logic [19:0] s;
        int e0, l0, s0, o;
        e0 = n_early;
        l0 = n_late;
        s0 = n_stat;
        s = 20'h00000;
        o = int'(pcw[15:10]);
        for (int k = 0; k < (pcw[8] ? len - 4 : len); k++) begin
            q.push_back(8'(k + 1));
        end
        // Header checksum worked out from the frame bytes, field left out
        for (int k = 0; o != 0 && k < 20; k += 2) begin
            if (k != 10) begin
                s += 20'({q[o + k], q[o + k + 1]});
            end
        end
        s = 20'(s[15:0]) + 20'(s[19:16]);
        s = 20'(s[15:0]) + 20'(s[19:16]);
        if (o != 0) begin
            q[o + 10] = ~s[15:8];
            q[o + 11] = ~s[7:0];
        end
        while (!pcw[6] && q.size() < (pcw[9:8] != 0 ? 60 : 64)) begin
            q.push_back(8'h00);
        end
        c = crc_of(q);
        for (int b = 0; b < 4 && pcw[9:8] != 0; b++) begin
            q.push_back(c[8 * b +: 8]);
        end
        col_req <= col;
        bus(1'b1, 32'(tpcw_pkg::ADDR_PCW), pcw, rd);
        bus(1'b1, 32'(tpcw_pkg::ADDR_LEN), 32'(len), rd);
        bus(1'b1, 32'(tpcw_pkg::ADDR_SETUP), 32'h00000001, rd);
        for (int w = 0; w < (len + 3) / 4; w++) begin
            if (w == hold) begin
                repeat (60) @(posedge hclk);
                chk("tx_en held", 32'(tx_en), 32'h0);
            end
            bus(1'b1, 32'(tpcw_pkg::ADDR_DATA), {8'(4 * w + 4), 8'(4 * w + 3),
                8'(4 * w + 2), 8'(4 * w + 1)}, rd);
        end
        for (int i = 0; i < 30000 && n_stat == s0; i++) @(posedge hclk);
        col_req <= 1'b0;
        chk("status entry", 32'(n_stat - s0), 32'h1);
        chk("collision irq", 32'(n_coll), 32'h0);
        chk("byte count", 32'(nbytes), 32'(q.size()));
        foreach (q[i]) chk("byte", 32'(u_phy.rx[i]), 32'(q[i]));
        chk("status id", 32'(status_id), 32'(pcw[24:16]));
        chk("early", 32'(n_early - e0), 32'(pcw[4]));
        chk("late", 32'(n_late - l0), 32'(pcw[5]));
        chk("abort", 32'(status_abort), 32'h0);
        $display("test done for control word %h", pcw);
    endtask : run
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = tpcw_pkg::HSIZE_WORD;
        hwdata = 32'h00000000;
        col_req = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("hreadyout", 32'(hreadyout), 32'h1);
        chk("hresp", 32'(hresp), 32'h0);
        bus(1'b0, 32'(tpcw_pkg::ADDR_PCW), 32'h0, rd);
        chk("control word read", rd, 32'h0);
        bus(1'b0, 32'h000003FC, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        $display("test done for register reads");
        run(32'hBF55_02B1, 40, 7, 1'b0);
        run(32'h10A2_0040, 8, -1, 1'b0);
        run(32'h1033_0140, 8, -1, 1'b0);
        run(32'h11FF_025A, 8, -1, 1'b1);
        run(32'h10C3_1220, 40, -1, 1'b0);
        tally_and_finish();
    end
    // Five short frames plus one back-off fit well inside this span
    initial begin
        repeat (60000) @(posedge hclk);
        fails++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
